// ===== pfc_dbg_host.sv
// Purpose: debug host and pin drivers facing the block
// Assumes: commands change just after a rising edge
// Notes:   released lines read high through the pullup
`timescale 1ns/100ps
module pfc_dbg_host (
   input wire logic clock,       // bus clock
   input wire logic rst,         // power-on reset
   input wire logic hold_low,    // keep strap low
   input wire logic pin_rst,     // pull reset pin low
   input wire logic cmd,         // debug command given
   input wire logic send,        // start one bit
   input wire logic bit_val,     // bit to send
   output logic strap_pin_in,    // strap level
   output logic reset_pin_in,    // reset pin level
   output logic bdc_drive_low,   // line pulled low
   output logic bdc_speedup,     // speedup pulse
   output logic debug_cmd_seen   // command flag
);
   logic [4:0] cnt_q; // bit time left
   // strap low on request; released line is pulled high
   assign strap_pin_in = !hold_low;
   assign reset_pin_in = !pin_rst;
   assign debug_cmd_seen = cmd;
   always_ff @(posedge clock) begin
      if (rst) cnt_q <= 5'h00;
      else if (send && cnt_q == 5'h00) cnt_q <= 5'h10;
      else if (cnt_q != 5'h00) cnt_q <= cnt_q - 5'h01;
   end
   // low phase, then a short high pulse, then release
   assign bdc_drive_low = cnt_q > (bit_val ? 5'h0c : 5'h03);
   assign bdc_speedup = cnt_q == (bit_val ? 5'h0c : 5'h03);
endmodule : pfc_dbg_host

// ===== pfc_pin_ctrl.sv
// Purpose: pin function, strap sampling and pull control for a small mcu
// Assumes: rst is power-on reset, synchronous; apb register access
// Notes:   pins outside the clock domain pass three flip-flops
`timescale 1ns/100ps
`include "pfc_regs.svh"

module pfc_pin_ctrl
   import pfc_pkg::*;
#(
   parameter int NPINS = 14  // pins under control
) (
   input  wire logic              clock,          // bus clock, 100 mhz
   input  wire logic              rst,            // power-on reset, active high
   input  wire logic              psel,           // apb select
   input  wire logic              penable,        // apb enable
   input  wire logic              pwrite,         // apb write
   input  wire logic [11:0]       paddr,          // apb byte address
   input  wire logic [31:0]       pwdata,         // apb write data
   output logic      [31:0]       prdata,         // apb read data
   output logic                   pready,         // apb ready
   output logic                   pslverr,        // apb error
   input  wire logic              reset_pin_in,   // level on shared reset pin
   input  wire logic              strap_pin_in,   // level on debug/strap pin
   input  wire logic              bdc_drive_low,  // debug ctrl pulls line low
   input  wire logic              bdc_speedup,    // debug ctrl drives high pulse
   input  wire logic              debug_cmd_seen, // debug command issued
   input  wire logic [NPINS-1:0]  port_out_dir,   // port logic drives pin
   input  wire logic [NPINS-1:0]  periph_out,     // shared peripheral drives pin
   input  wire logic [NPINS-1:0]  analog_own,     // analog function owns pin
   input  wire logic [NPINS-1:0]  kbi_rise,       // keyboard rising edge set
   input  wire logic              cmp_out_en,     // comparator output enabled
   input  wire logic              port4_out_en,   // port drives strap pin
   input  wire logic              port4_out_val,  // port value for strap pin
   input  wire logic              cmp_out_val,    // comparator value
   output logic                   sys_reset_req,  // request chip reset
   output logic                   bdm_mode,       // device in debug mode
   output logic                   reset_pin_func, // shared pin is reset input
   output logic                   bkg_pin_func,   // strap pin is debug line
   output logic                   dbg_line_o,     // debug line output value
   output logic                   dbg_line_oe,    // debug line output enable
   output logic      [NPINS-1:0]  pullup_on,      // pullup device active
   output logic      [NPINS-1:0]  pulldown_on,    // pulldown device active
   output logic      [NPINS-1:0]  slew_on,        // slew limiting active
   output logic      [NPINS-1:0]  high_drive      // high drive active
);

   // ========================================================================
   // state
   typedef struct packed {
      logic [2:0]       rpin_sync;  // reset pin synchroniser
      logic [2:0]       strap_sync; // strap pin synchroniser
      logic             rst_en;     // reset function latched
      logic             bkg_en;     // background function enabled
      logic             background_debug_mode;        // debug mode
      pfc_rst_e         rst_st;     // reset sequencing state
      logic [3:0]       frst_cnt;   // forced reset length counter
      logic [NPINS-1:0] pull_en;    // pull device enable bits (pullup or pulldown)
      logic [NPINS-1:0] slew_en;    // slew enable bits
      logic [NPINS-1:0] drv_en;     // drive strength bits
      logic [31:0]      rdata;      // read data
      logic             ready;      // apb ready
      logic             err;        // apb error
      logic             sreq;       // reset request
      logic             dbg_o;      // debug line value
      logic             dbg_oe;     // debug line enable
      pfc_pull_s        pull;       // pull outputs
      pfc_pad_s         pad;        // pad outputs
   } pfc_state_s;

   pfc_state_s s_q;  // registered state
   pfc_state_s s_d;  // next state

   logic        acc;     // apb access phase
   logic        wr;      // apb write this cycle
   logic        rpin_lo; // filtered reset pin low
   logic        strap_lo; // filtered strap low
   logic [NPINS-1:0] out_any; // pin is driven out

   // ========================================================================
   // next state
   always_comb begin
      s_d = s_q;
      acc = psel & penable & ~s_q.ready;
      wr  = acc & pwrite;
      // three-stage synchronisers; a low counts only when stages 2 and 3 agree
      s_d.rpin_sync  = {s_q.rpin_sync[1:0], reset_pin_in};
      s_d.strap_sync = {s_q.strap_sync[1:0], strap_pin_in};
      rpin_lo  = ~s_q.rpin_sync[1] & ~s_q.rpin_sync[2];
      strap_lo = ~s_q.strap_sync[1] & ~s_q.strap_sync[2];
      s_d.sreq = 1'b0;

      // apb slave: one wait state, errors on unmapped offsets
      s_d.ready = acc;
      s_d.err   = 1'b0;
      s_d.rdata = 32'h0000_0000;
      if (acc) begin
         case (paddr)
            `PFC_SYSOPT_OFF: begin
               s_d.rdata[`PFC_RSTPIN_BIT] = s_q.rst_en;
               s_d.rdata[`PFC_BKGPIN_BIT] = s_q.bkg_en;
               if (wr) begin
                  s_d.rst_en = s_q.rst_en | pwdata[`PFC_RSTPIN_BIT];
                  s_d.bkg_en = pwdata[`PFC_BKGPIN_BIT];
               end
            end
            `PFC_FORCE_RST_OFF: begin
               if (wr && pwdata[`PFC_FORCE_BIT] && debug_cmd_seen) begin
                  s_d.rst_st   = pfc_st_frst;
                  s_d.frst_cnt = 4'h0;
               end
            end
            `PFC_PULL_EN_OFF: begin
               s_d.rdata[NPINS-1:0] = s_q.pull_en;
               if (wr) begin
                  s_d.pull_en = pwdata[NPINS-1:0];
               end
            end
            `PFC_SLEW_EN_OFF: begin
               s_d.rdata[NPINS-1:0] = s_q.slew_en;
               if (wr) begin
                  s_d.slew_en = pwdata[NPINS-1:0];
               end
            end
            `PFC_DRIVE_OFF: begin
               s_d.rdata[NPINS-1:0] = s_q.drv_en;
               if (wr) begin
                  s_d.drv_en = pwdata[NPINS-1:0];
               end
            end
            `PFC_STATUS_OFF: begin
               s_d.rdata[`PFC_ST_BDM_BIT]    = s_q.background_debug_mode;
               s_d.rdata[`PFC_ST_RSTPIN_BIT] = rpin_lo;
            end
            default: begin
               s_d.err = 1'b1;
            end
         endcase
      end

      // reset sequencing: forced reset holds, then strap decides mode
      case (s_q.rst_st)
         pfc_st_run: begin
            if (s_q.rst_en && rpin_lo) begin
               s_d.sreq   = 1'b1;
               s_d.background_debug_mode    = 1'b0;
               s_d.bkg_en = 1'b1;
            end
         end
         pfc_st_frst: begin
            s_d.sreq     = 1'b1;
            s_d.bkg_en   = 1'b1;
            s_d.frst_cnt = s_q.frst_cnt + 4'h1;
            if (s_q.frst_cnt == 4'(`PFC_FRST_CYCLES - 1)) begin
               s_d.rst_st = pfc_st_strap;
            end
         end
         pfc_st_strap: begin
            s_d.background_debug_mode    = strap_lo;
            s_d.rst_st = pfc_st_run;
         end
         default: begin
            s_d.rst_st = pfc_st_run;
         end
      endcase

      // pseudo open drain line: low pulls, brief high speedups
      // bit timing belongs to the debug controller
      // debug line outranks comparator, comparator outranks port
      if (s_q.bkg_en) begin
         s_d.dbg_oe = bdc_drive_low | bdc_speedup;
         s_d.dbg_o  = bdc_speedup & ~bdc_drive_low;
      end else if (cmp_out_en) begin
         s_d.dbg_oe = 1'b1;
         s_d.dbg_o  = cmp_out_val;
      end else begin
         s_d.dbg_oe = port4_out_en;
         s_d.dbg_o  = port4_out_val;
      end

      out_any = port_out_dir | periph_out;
      out_any[4] = s_d.dbg_oe;
      for (int i = 0; i < NPINS; i++) begin
         s_d.pull.up[i]   = s_q.pull_en[i] & ~out_any[i] & ~analog_own[i]
                            & ~kbi_rise[i];
         s_d.pull.down[i] = s_q.pull_en[i] & ~out_any[i] & ~analog_own[i]
                            & kbi_rise[i];
      end
      if (s_q.rst_en) begin
         s_d.pull.up[5]   = 1'b1;
         s_d.pull.down[5] = 1'b0;
      end
      if (s_q.bkg_en) begin
         s_d.pull.up[4]   = 1'b1;
         s_d.pull.down[4] = 1'b0;
      end
      s_d.pad.slew  = s_q.slew_en & out_any;
      s_d.pad.drive = s_q.drv_en & out_any;
      // output-only pin always drives
      s_d.pad.slew[NPINS-1]  = s_q.slew_en[NPINS-1];
      s_d.pad.drive[NPINS-1] = s_q.drv_en[NPINS-1];
   end

   // ========================================================================
   // registers
   always_ff @(posedge clock) begin
      if (rst) begin
         s_q            <= '0;
         s_q.rst_en     <= 1'b0;
         s_q.bkg_en     <= 1'b1;
         s_q.rpin_sync  <= 3'h7;
         s_q.strap_sync <= 3'h7;
         s_q.rst_st     <= pfc_st_strap;
         s_q.pull_en    <= `PFC_PULL_RST;
         s_q.slew_en    <= `PFC_SLEW_RST;
         s_q.drv_en     <= `PFC_DRIVE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ========================================================================
   // outputs straight from flip-flops
   always_comb begin
      prdata         = s_q.rdata;
      pready         = s_q.ready;
      pslverr        = s_q.err;
      sys_reset_req  = s_q.sreq;
      bdm_mode       = s_q.background_debug_mode;
      reset_pin_func = s_q.rst_en;
      bkg_pin_func   = s_q.bkg_en;
      dbg_line_o     = s_q.dbg_o;
      dbg_line_oe    = s_q.dbg_oe;
      pullup_on      = s_q.pull.up;
      pulldown_on    = s_q.pull.down;
      slew_on        = s_q.pad.slew;
      high_drive     = s_q.pad.drive;
   end

endmodule : pfc_pin_ctrl

// ===== pfc_pin_ctrl_properties.sv
// Purpose: concurrent checks on the pin control ports
// Assumes: pull outputs lag their inputs by one cycle
// Notes:   bound to every pfc_pin_ctrl instance below
`timescale 1ns/100ps
module pfc_chk #(parameter int NPINS = 14) (
   input wire logic clock,              // bus clock
   input wire logic rst,                // power-on reset
   input wire logic psel,               // apb select
   input wire logic penable,            // apb enable
   input wire logic pready,             // apb ready
   input wire logic bdc_drive_low,      // line pulled low
   input wire logic bdc_speedup,        // line speedup pulse
   input wire logic reset_pin_func,     // reset pin mode
   input wire logic bkg_pin_func,       // debug line mode
   input wire logic dbg_line_o,         // line value
   input wire logic dbg_line_oe,        // line drive
   input wire logic [NPINS-1:0] port_out_dir, // port drives
   input wire logic [NPINS-1:0] periph_out,   // peripheral drives
   input wire logic [NPINS-1:0] analog_own,   // analog owns
   input wire logic [NPINS-1:0] kbi_rise,     // rising edge set
   input wire logic [NPINS-1:0] pullup_on,    // pullups
   input wire logic [NPINS-1:0] pulldown_on   // pulldowns
);
   // pins 4 and 5 carry fixed pulls of their own
   localparam logic [NPINS-1:0] MSK = ~(NPINS'(6'h30));
   logic [NPINS-1:0] blk_q; // last cycle's pull blockers
   logic [NPINS-1:0] kbi_q; // last cycle's edge select
   // ==========================================
   // helper registers
   always_ff @(posedge clock) begin
      blk_q <= port_out_dir | periph_out | analog_own;
      kbi_q <= kbi_rise;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_access; psel && penable && !pready; endsequence
   sequence s_rst_held; reset_pin_func ##1 reset_pin_func; endsequence
   sequence s_bkg_quiet; (bkg_pin_func && !dbg_line_oe) [*2]; endsequence
   a_ready_one_wait: assert property (s_access |=> pready)
      else $error("ready not one cycle after access");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_pull_blocked: assert property (((pullup_on | pulldown_on) & blk_q & MSK) == '0)
      else $error("pull on a driven or analog pin");
   a_pull_kbi_dir: assert property (((pullup_on & kbi_q & MSK) | (pulldown_on & ~kbi_q)) == '0)
      else $error("pull polarity wrong");
   a_rst_sticky: assert property (reset_pin_func |=> reset_pin_func)
      else $error("reset pin mode dropped");
   a_rst_pull: assert property (s_rst_held |-> pullup_on[5])
      else $error("reset pin pullup off");
   a_bkg_pull: assert property (s_bkg_quiet |-> pullup_on[4])
      else $error("debug line pullup off");
   a_line_low: assert property (bkg_pin_func && bdc_drive_low && !bdc_speedup
      |=> dbg_line_oe && !dbg_line_o) else $error("line not pulled low");
   a_line_fast: assert property (bkg_pin_func && bdc_speedup && !bdc_drive_low
      |=> dbg_line_oe && dbg_line_o) else $error("speedup pulse missing");
endmodule : pfc_chk
bind pfc_pin_ctrl pfc_chk #(.NPINS(NPINS)) chk (.clock(clock), .rst(rst), .psel(psel),
   .penable(penable), .pready(pready), .bdc_drive_low(bdc_drive_low),
   .bdc_speedup(bdc_speedup), .reset_pin_func(reset_pin_func), .bkg_pin_func(bkg_pin_func),
   .dbg_line_o(dbg_line_o), .dbg_line_oe(dbg_line_oe), .port_out_dir(port_out_dir),
   .periph_out(periph_out), .analog_own(analog_own), .kbi_rise(kbi_rise),
   .pullup_on(pullup_on), .pulldown_on(pulldown_on));

// ===== pfc_pin_ctrl_tb.sv
// Purpose: self-checking bench for pfc_pin_ctrl
// Assumes: apb answers one wait cycle after the access edge
// Notes:   read results are checked by a monitor from a queue
`timescale 1ns/100ps
`include "pfc_regs.svh"
module pfc_pin_ctrl_tb;
   import pfc_pkg::*;
   logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rnd, rnd2, st = 32'd49207;
   logic pready, pslverr, sys_reset_req, bdm_mode, reset_pin_func, bkg_pin_func;
   logic dbg_line_o, dbg_line_oe, strap_pin_in, reset_pin_in, bdc_drive_low, bdc_speedup;
   logic debug_cmd_seen, hold_low = 0, pin_rst = 0, cmd = 0, send = 0, bit_val = 0;
   logic cmp_out_en = 0, port4_out_en = 0, port4_out_val = 0, cmp_out_val = 0;
   logic [13:0] port_out_dir = '0, periph_out = '0, analog_own = '0, kbi_rise = '0;
   logic [13:0] pullup_on, pulldown_on, slew_on, high_drive, blk, en;
   logic [64:0] expq[$]; // error, mask, value of each transfer
   logic [64:0] e;
   int n_errors = 0, total_checks = 0, k;
   initial forever #5 clock = ~clock;
   pfc_pin_ctrl #(.NPINS(14)) uut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .reset_pin_in(reset_pin_in), .strap_pin_in(strap_pin_in),
      .bdc_drive_low(bdc_drive_low), .bdc_speedup(bdc_speedup),
      .debug_cmd_seen(debug_cmd_seen), .port_out_dir(port_out_dir), .periph_out(periph_out),
      .analog_own(analog_own), .kbi_rise(kbi_rise), .cmp_out_en(cmp_out_en),
      .port4_out_en(port4_out_en), .port4_out_val(port4_out_val), .cmp_out_val(cmp_out_val),
      .sys_reset_req(sys_reset_req), .bdm_mode(bdm_mode), .reset_pin_func(reset_pin_func),
      .bkg_pin_func(bkg_pin_func), .dbg_line_o(dbg_line_o), .dbg_line_oe(dbg_line_oe),
      .pullup_on(pullup_on), .pulldown_on(pulldown_on), .slew_on(slew_on),
      .high_drive(high_drive));
   pfc_dbg_host host (.clock(clock), .rst(rst), .hold_low(hold_low), .pin_rst(pin_rst),
      .cmd(cmd), .send(send), .bit_val(bit_val), .strap_pin_in(strap_pin_in),
      .reset_pin_in(reset_pin_in), .bdc_drive_low(bdc_drive_low),
      .bdc_speedup(bdc_speedup), .debug_cmd_seen(debug_cmd_seen));
   // ==========================================
   // helpers
   function automatic logic [31:0] xs();
      st = st ^ (st << 13);
      st = st ^ (st >> 17);
      st = st ^ (st << 5);
      return st;
   endfunction : xs
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [31:0] m, input logic [31:0] x, input logic err);
      @(posedge clock);
      expq.push_back({err, m, x});
      {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      {psel, penable} <= 2'b00;
   endtask : apb
   task automatic frc(input logic h);
      hold_low <= h;
      apb(1'b1, `PFC_FORCE_RST_OFF, 32'h1, 32'h0, 32'h0, 1'b0);
      for (k = 0; sys_reset_req !== 1'b1 && k < 20; k++) @(posedge clock);
      for (k = 0; sys_reset_req === 1'b1 && k < 20; k++) @(posedge clock);
      chk(32'(k), 32'(`PFC_FRST_CYCLES));
      repeat (6) @(posedge clock);
      hold_low <= 1'b0;
      chk(32'({bdm_mode, bkg_pin_func}), {30'h0, h, 1'b1});
   endtask : frc
   task automatic summarize();
      if (n_errors == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : summarize
   // monitor: oldest note against each answer
   always @(posedge clock) begin
      if (pready === 1'b1 && expq.size() > 0) begin
         e = expq.pop_front();
         chk({31'h0, pslverr}, {31'h0, e[64]});
         chk(prdata & e[63:32], e[31:0]);
      end
   end
   initial begin
      #200000;
      n_errors++;
      summarize();
   end
   // ==========================================
   // scenarios
   initial begin
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      // pulls and pads settle on the first free-running edge, checked one edge later
      repeat (2) @(posedge clock);
      chk(32'({sys_reset_req, bdm_mode, reset_pin_func, bkg_pin_func}), 32'h1);
      chk(32'({pullup_on, pulldown_on}), 32'h00040000);
      chk(32'({slew_on, high_drive}), 32'h08000000);
      apb(1'b0, `PFC_SYSOPT_OFF, 32'h0, 32'h3, 32'h2, 1'b0);
      apb(1'b0, `PFC_SLEW_EN_OFF, 32'h0, 32'hffffffff, 32'h2000, 1'b0);
      apb(1'b0, `PFC_PULL_EN_OFF, 32'h0, 32'hffffffff, 32'h0, 1'b0);
      apb(1'b0, 12'h018, 32'h0, 32'hffffffff, 32'h0, 1'b1);
      for (k = 0; k < 2; k++) begin
         {send, bit_val} <= {1'b1, k[0]};
         @(posedge clock);
         send <= 1'b0;
         repeat (18) @(posedge clock);
      end
      apb(1'b1, `PFC_SYSOPT_OFF, 32'h0, 32'h0, 32'h0, 1'b0);
      rnd = xs();
      en = rnd[13:0];
      apb(1'b1, `PFC_PULL_EN_OFF, {18'h0, en}, 32'h0, 32'h0, 1'b0);
      apb(1'b1, `PFC_DRIVE_OFF, rnd, 32'h0, 32'h0, 1'b0);
      apb(1'b0, `PFC_DRIVE_OFF, 32'h0, 32'h3fff, rnd & 32'h3fff, 1'b0);
      // drive only shows on outputs; pin 4 follows its own enable, held low here
      port_out_dir <= 14'h3fff;
      repeat (2) @(posedge clock);
      chk(32'(high_drive), rnd & 32'h3fef);
      for (int i = 0; i < 24; i++) begin
         rnd = xs();
         rnd2 = xs();
         {port_out_dir, periph_out, cmp_out_en, cmp_out_val} <= rnd[29:0];
         {analog_own, kbi_rise, port4_out_en, port4_out_val} <= rnd2[29:0];
         blk = rnd[29:16] | rnd[15:2] | rnd2[29:16];
         repeat (2) @(posedge clock);
         chk(32'(pullup_on & 14'h3fcf), 32'(en & ~blk & ~rnd2[15:2] & 14'h3fcf));
         chk(32'(pulldown_on & 14'h3fcf), 32'(en & ~blk & rnd2[15:2] & 14'h3fcf));
      end
      apb(1'b1, `PFC_SYSOPT_OFF, 32'h1, 32'h0, 32'h0, 1'b0);
      apb(1'b1, `PFC_SYSOPT_OFF, 32'h0, 32'h0, 32'h0, 1'b0);
      repeat (2) @(posedge clock);
      chk(32'({reset_pin_func, pullup_on[5]}), 32'h3);
      cmd <= 1'b1;
      frc(1'b1);
      apb(1'b0, `PFC_STATUS_OFF, 32'h0, 32'h1, 32'h1, 1'b0);
      apb(1'b1, `PFC_SYSOPT_OFF, 32'h0, 32'h0, 32'h0, 1'b0);
      {pin_rst, hold_low} <= 2'b11;
      repeat (8) @(posedge clock);
      chk(32'(sys_reset_req), 32'h1);
      pin_rst <= 1'b0;
      repeat (8) @(posedge clock);
      hold_low <= 1'b0;
      chk(32'({bdm_mode, bkg_pin_func}), 32'h1);
      apb(1'b1, `PFC_SYSOPT_OFF, 32'h0, 32'h0, 32'h0, 1'b0);
      frc(1'b0);
      summarize();
   end
endmodule : pfc_pin_ctrl_tb

// ===== pfc_pkg.sv
// Purpose: types for the pin function and pull control block
// Assumes: 14 pins, pin 13 is the output-only pin
// Notes:   offsets and counts live in pfc_regs.svh
package pfc_pkg;
   // pull device steering per pin
   typedef struct packed {
      logic [13:0] up;   // pullup on
      logic [13:0] down; // pulldown on
   } pfc_pull_s;

   // pad drive controls per pin
   typedef struct packed {
      logic [13:0] slew;  // slew limit active
      logic [13:0] drive; // high drive selected
   } pfc_pad_s;

   // reset sequencing states
   typedef enum logic [1:0] {
      pfc_st_run,
      pfc_st_frst,
      pfc_st_strap
   } pfc_rst_e;
endpackage : pfc_pkg

// ===== pfc_regs.svh
// Purpose: register offsets, field positions and reset values for pin control
// Assumes: apb with 32-bit data, one register per aligned word
// Notes:   all offsets here are byte addresses
`ifndef PFC_REGS_SVH
`define PFC_REGS_SVH

// ==========================================================================
// register offsets
`define PFC_SYSOPT_OFF     12'h000
`define PFC_FORCE_RST_OFF  12'h004
`define PFC_PULL_EN_OFF    12'h008
`define PFC_SLEW_EN_OFF    12'h00c
`define PFC_DRIVE_OFF      12'h010
`define PFC_STATUS_OFF     12'h014

// ==========================================================================
// system option register one fields
`define PFC_RSTPIN_BIT     0
`define PFC_BKGPIN_BIT     1
// debug force reset register field
`define PFC_FORCE_BIT      0
// status register fields
`define PFC_ST_BDM_BIT     0
`define PFC_ST_RSTPIN_BIT  1

// ==========================================================================
// reset values
`define PFC_PULL_RST       14'h0000
`define PFC_SLEW_RST       14'h2000
`define PFC_DRIVE_RST      14'h0000

// ==========================================================================
// timing
`define PFC_BIT_CYCLES     16
`define PFC_FRST_CYCLES    4

`endif
